/* bridge_port_cfg.svh */
// Constants of the half-bridge serial command port: field positions, reset values, timing.
// Assumes inclusion by the package and the port module only.
`ifndef BRIDGE_PORT_CFG_SVH
`define BRIDGE_PORT_CFG_SVH

`define FRAME_BITS 16
`define CHANNELS 12
`define GROUP_CHANNELS 6

// Command word field positions.
`define CMD_STATUS_CLEAR 15
`define CMD_GROUP_SELECT 14
`define CMD_UNDERLOAD_EN 13
`define CMD_ENABLE_HI 12
`define CMD_ENABLE_LO 7
`define CMD_SIDE_HI 6
`define CMD_SIDE_LO 1
`define CMD_OVERVOLTAGE_LOCKOUT_ENABLE_EN 0

// Status word field positions.
`define STS_OVERCURRENT 15
`define STS_SUPPLY_FAULT 14
`define STS_UNDERLOAD 13
`define STS_THERMAL_WARN 0

// Reset values.
`define CMD_RESET_VALUE 16'h0000
`define STATUS_RESET_VALUE 16'h0000

// Timing: core clock rate and wake-up time from enable high to a usable port.
`define CORE_CLK_HZ 20000000
`define WAKE_TIME_US 100
`define WAKE_CYCLES ((`WAKE_TIME_US * `CORE_CLK_HZ) / 1000000)

// Frame checks.
`define MIN_FRAME_EDGES 16
`define FRAME_GRANULE_MASK 3'h7

`endif

/* bridge_port_pkg.sv */
// Types shared by the half-bridge serial command port.
// Assumes bridge_port_cfg.svh is on the include path.
`include "bridge_port_cfg.svh"

package bridge_port_pkg;

  // Two-bit per-channel state code, priority encoded.
  typedef enum logic [1:0] {
    BRIDGE_OFF = 2'h0,
    BRIDGE_OVERCURRENT = 2'h1,
    BRIDGE_UNDERLOAD = 2'h2,
    BRIDGE_ON = 2'h3
  } bridge_state_code_e;

  typedef logic [`CHANNELS-1:0] chan_mask_t;

  typedef struct packed {
    logic [11:0] wakeCount;
    logic ready;
    logic sclkLast;
    logic csLast;
    logic inFrame;
    logic [7:0] edgeCount;
    logic manyEdges;
    logic [`FRAME_BITS-1:0] rxShift;
    logic [`FRAME_BITS-1:0] txShift;
    logic soBit;
    logic channelGroupSelect;
    logic overvoltageLockoutEnable;
    logic [1:0] underloadShutdownEnable;
    chan_mask_t bridgeOutputEnable;
    chan_mask_t bridgeDriveSide;
    chan_mask_t overcurrentLatch;
    chan_mask_t underloadLatch;
    logic thermalShutdownLatch;
  } port_state_s;

endpackage

/* half_bridge_spi_command_port.sv */
// Serial command and status port of a twelve-channel half-bridge driver.
// Assumes the serial pins and the enable pin are asynchronous to core_clk; fault inputs are on core_clk.
// Behaviour
// - Enable low clears all configuration and latched status, switches drivers off, sleeps.
// - After enable rises, a wake-up delay passes before programming is accepted.
// - Frames are accepted only while enable is high.
// - Each good frame exchanges 16 bits, or a longer multiple of 8 when chained, each way plus a leading pseudo-bit out.
// - Thermal shutdown flag is on the output from select fall to first clock rise.
// - Select falling starts a frame; pseudo-bit appears at once.
// - Command bits enter on falling clock edges, MSB first, status clear first.
// - Input bits are sampled on the falling clock edge.
// - Status bits leave on rising edges, MSB first, overcurrent first.
// - Select rising ends the frame and the output goes high impedance.
// - Last 16 bits load the command only if the frame had no error.
// - Command layout: clear, group, underload, six enables, six sides, overvoltage lockout.
// - Group bit one targets channels 12..7; zero targets channels 6..1.
// - Per channel: enable zero is off, one on; side zero low, one high.
// - Status clear wipes latched faults of the selected group.
// - All command bits are zero after power-on reset.
// - Status word: overcurrent, supply, underload, six state pairs, thermal warning.
// - Latched status bits are zero after power-on reset; the supply and thermal warning bits follow their inputs.
`include "bridge_port_cfg.svh"

module half_bridge_spi_command_port
  import bridge_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Enable pin
  input wire logic enable,
  // Serial pins
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  output logic soOe,
  // Fault detectors
  input wire bridge_port_pkg::chan_mask_t overcurrentDetect,
  input wire bridge_port_pkg::chan_mask_t underloadDetect,
  input wire logic thermalShutdownDetect,
  input wire logic thermalWarningDetect,
  input wire logic supplyFault,
  // Driver controls
  output bridge_port_pkg::chan_mask_t driveEnable,
  output bridge_port_pkg::chan_mask_t driveHighSide,
  output logic sleep
);
  import bridge_port_pkg::*;

  localparam logic [11:0] WAKE_COUNT = 12'(`WAKE_CYCLES);

  port_state_s state;
  port_state_s next_state;

  // Synchronised pins, in order enable, chip select, clock, data.
  pin_sync_if #(.WIDTH(4)) pins ();

  // Chip select idles high so a frame is never seen while the synchroniser fills.
  pin_sync #(
    .WIDTH(4),
    .RESET_LEVEL(4'h4)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinRaw({enable, chip_select_n, sclk, si}),
    .syncOut(pins)
  );

  logic enSync;
  logic csSync;
  logic sclkSync;
  logic siSync;
  logic sclkRise;
  logic sclkFall;
  logic csFall;
  logic csRise;
  logic frameGood;
  logic [`FRAME_BITS-1:0] statusWord;
  logic [`FRAME_BITS-1:0] command;
  chan_mask_t groupMask;
  chan_mask_t clearMask;

  assign enSync = pins.level[3];
  assign csSync = pins.level[2];
  assign sclkSync = pins.level[1];
  assign siSync = pins.level[0];

  assign sclkRise = sclkSync && !state.sclkLast;
  assign sclkFall = !sclkSync && state.sclkLast;
  assign csFall = !csSync && state.csLast;
  assign csRise = csSync && !state.csLast;

  // Per-channel state code, overcurrent first, then underload, then enabled.
  function automatic bridge_state_code_e channel_code(input logic oc, input logic underload_flag, input logic on);
    bridge_state_code_e code;
    code = BRIDGE_OFF;
    if (oc) begin
      code = BRIDGE_OVERCURRENT;
    end else if (underload_flag) begin
      code = BRIDGE_UNDERLOAD;
    end else if (on) begin
      code = BRIDGE_ON;
    end
    return code;
  endfunction

  // Status word of the group chosen by the last accepted frame.
  always_comb begin
    int base;
    base = state.channelGroupSelect ? `GROUP_CHANNELS : 0;
    statusWord = `STATUS_RESET_VALUE;
    for (int i = 0; i < `GROUP_CHANNELS; i++) begin
      statusWord[`STS_OVERCURRENT] = statusWord[`STS_OVERCURRENT] | state.overcurrentLatch[base + i];
      statusWord[`STS_UNDERLOAD] = statusWord[`STS_UNDERLOAD] | state.underloadLatch[base + i];
      statusWord[2 * i + 2 -: 2] = channel_code(state.overcurrentLatch[base + i],
                                                state.underloadLatch[base + i],
                                                driveEnable[base + i]);
    end
    statusWord[`STS_SUPPLY_FAULT] = supplyFault;
    statusWord[`STS_THERMAL_WARN] = thermalWarningDetect;
  end

  // Frame check on rising-edge count.
  assign frameGood = state.manyEdges && ((state.edgeCount[2:0] & `FRAME_GRANULE_MASK) == 3'h0);
  assign command = state.rxShift;

  // Mask of the group that a received status-clear request addresses.
  always_comb begin
    groupMask = '0;
    for (int i = 0; i < `GROUP_CHANNELS; i++) begin
      if (command[`CMD_GROUP_SELECT]) begin
        groupMask[`GROUP_CHANNELS + i] = 1'b1;
      end else begin
        groupMask[i] = 1'b1;
      end
    end
    clearMask = (csRise && state.inFrame && frameGood && command[`CMD_STATUS_CLEAR]) ? groupMask : '0;
  end

  always_comb begin
    next_state = state;
    next_state.sclkLast = sclkSync;
    next_state.csLast = csSync;

    // Wake-up timer runs once enable is high; the port stays deaf until it expires.
    if (!state.ready) begin
      if (state.wakeCount == WAKE_COUNT - 12'h001) begin
        next_state.ready = 1'b1;
      end else begin
        next_state.wakeCount = state.wakeCount + 12'h001;
      end
    end

    // Frame start: pseudo-bit is the latched thermal shutdown flag.
    if (csFall && state.ready) begin
      next_state.inFrame = 1'b1;
      next_state.edgeCount = 8'h00;
      next_state.manyEdges = 1'b0;
      next_state.soBit = state.thermalShutdownLatch;
      next_state.txShift = statusWord;
    end else if (state.inFrame && !csSync) begin
      if (sclkRise) begin
        // The output register follows the shift register head on each rise.
        next_state.soBit = state.txShift[`FRAME_BITS-1];
        next_state.edgeCount = state.edgeCount + 8'h01;
        if (state.edgeCount == 8'(`MIN_FRAME_EDGES - 1)) begin
          next_state.manyEdges = 1'b1;
        end
      end
      if (sclkFall) begin
        // Received bits follow the status out, which lets devices chain.
        next_state.rxShift = {state.rxShift[`FRAME_BITS-2:0], siSync};
        next_state.txShift = {state.txShift[`FRAME_BITS-2:0], siSync};
      end
    end

    // Frame end: accept or discard, then release the output.
    if (csRise && state.inFrame) begin
      next_state.inFrame = 1'b0;
      if (frameGood) begin
        next_state.channelGroupSelect = command[`CMD_GROUP_SELECT];
        next_state.overvoltageLockoutEnable = command[`CMD_OVERVOLTAGE_LOCKOUT_ENABLE_EN];
        next_state.underloadShutdownEnable[command[`CMD_GROUP_SELECT]] = command[`CMD_UNDERLOAD_EN];
        for (int i = 0; i < `GROUP_CHANNELS; i++) begin
          if (command[`CMD_GROUP_SELECT]) begin
            next_state.bridgeOutputEnable[`GROUP_CHANNELS + i] = command[`CMD_ENABLE_LO + i];
            next_state.bridgeDriveSide[`GROUP_CHANNELS + i] = command[`CMD_SIDE_LO + i];
          end else begin
            next_state.bridgeOutputEnable[i] = command[`CMD_ENABLE_LO + i];
            next_state.bridgeDriveSide[i] = command[`CMD_SIDE_LO + i];
          end
        end
        if (command[`CMD_STATUS_CLEAR]) begin
          next_state.thermalShutdownLatch = 1'b0;
        end
      end
    end

    // Fault latches: a new detection wins over a clear in the same cycle.
    next_state.overcurrentLatch = (state.overcurrentLatch & ~clearMask) | overcurrentDetect;
    next_state.underloadLatch = (state.underloadLatch & ~clearMask) | underloadDetect;
    if (thermalShutdownDetect) begin
      next_state.thermalShutdownLatch = 1'b1;
    end

    // Enable low wipes everything but the select and clock edge history, including the wake-up timer.
    if (!enSync) begin
      next_state = '0;
      next_state.sclkLast = sclkSync;
      next_state.csLast = csSync;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Drivers: a channel runs only if enabled and not held off by a latched fault.
  // Gating by the synchronised enable cuts the drivers in the cycle sleep rises, not one cycle later.
  always_comb begin
    for (int i = 0; i < `CHANNELS; i++) begin
      driveEnable[i] = enSync && state.ready && state.bridgeOutputEnable[i] && !state.overcurrentLatch[i]
                       && !(state.underloadLatch[i] && state.underloadShutdownEnable[i / `GROUP_CHANNELS])
                       && !state.thermalShutdownLatch
                       && !(supplyFault && state.overvoltageLockoutEnable);
      driveHighSide[i] = driveEnable[i] && state.bridgeDriveSide[i];
    end
  end

  assign sleep = !enSync;
  assign so = state.soBit;
  assign soOe = state.inFrame && enSync;
endmodule

/* half_bridge_spi_command_port_props.sv */
// Concurrent checks on the pins of the half-bridge serial command port.
// Assumes binding to that port; fault inputs are core_clk levels.
module half_bridge_port_props
  import bridge_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pins
  input wire logic enable,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic so,
  input wire logic soOe,
  input wire logic sleep,
  // Faults and drives
  input wire bridge_port_pkg::chan_mask_t overcurrentDetect,
  input wire logic thermalShutdownDetect,
  input wire bridge_port_pkg::chan_mask_t driveEnable,
  input wire bridge_port_pkg::chan_mask_t driveHighSide
);
  logic [11:0] awake;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Saturates so that a long awake spell cannot wrap back under the limit.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) awake <= 12'h000;
    else if (sleep) awake <= 12'h000;
    else if (awake != 12'hFFF) awake <= awake + 12'h001;
  end
  a_wake_before_frame: assert property (soOe |-> awake >= 12'h7D0)
    else $error("port answered before wake-up ended");
  a_sleep_follows_enable: assert property (!enable [*4] |-> sleep)
    else $error("enable low without sleep");
  a_sleep_all_off: assert property (sleep |-> driveEnable == '0 && !soOe)
    else $error("drive or output active while asleep");
  a_idle_high_z: assert property (chip_select_n [*6] |-> !soOe)
    else $error("output driven after select high");
  a_side_needs_enable: assert property ((driveHighSide & ~driveEnable) == '0)
    else $error("high side on a disabled channel");
  a_drive_held_in_frame: assert property (soOe && $past(soOe) && !sleep && overcurrentDetect == '0
    && !thermalShutdownDetect |-> $stable(driveEnable)) else $error("drive changed inside a frame");
  a_so_holds_still: assert property ((soOe && $stable(sclk)) [*6] |-> $stable(so))
    else $error("output moved without a clock edge");
  a_overcurrent_cuts: assert property (|overcurrentDetect |=> (driveEnable & $past(overcurrentDetect)) == '0)
    else $error("overcurrent channel still driven");
  a_thermal_cuts: assert property (thermalShutdownDetect |=> driveEnable == '0)
    else $error("drive on after thermal shutdown");
  cover property ($rose(soOe));
  cover property ($fell(sleep));
  cover property (|overcurrentDetect);
endmodule

bind half_bridge_spi_command_port half_bridge_port_props half_bridge_port_props_i (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .enable(enable),
  .chip_select_n(chip_select_n),
  .sclk(sclk),
  .so(so),
  .soOe(soOe),
  .sleep(sleep),
  .overcurrentDetect(overcurrentDetect),
  .thermalShutdownDetect(thermalShutdownDetect),
  .driveEnable(driveEnable),
  .driveHighSide(driveHighSide)
);

/* half_bridge_spi_command_port_tb.sv */
// Self-checking bench for the half-bridge serial command port.
// Assumes spi_host_model owns the serial pins; fault inputs change only between frames.
module half_bridge_spi_command_port_tb
  import bridge_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, enable, chip_select_n, sclk, si, so, soOe, sleep, pre;
  logic thermalShutdownDetect, thermalWarningDetect, supplyFault;
  chan_mask_t overcurrentDetect, underloadDetect, driveEnable, driveHighSide;
  logic [31:0] rx;
  int mismatches, num_checks, cycles;
  half_bridge_spi_command_port half_bridge_spi_command_port_i (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(enable),
    .chip_select_n(chip_select_n),
    .sclk(sclk),
    .si(si),
    .so(so),
    .soOe(soOe),
    .overcurrentDetect(overcurrentDetect),
    .underloadDetect(underloadDetect),
    .thermalShutdownDetect(thermalShutdownDetect),
    .thermalWarningDetect(thermalWarningDetect),
    .supplyFault(supplyFault),
    .driveEnable(driveEnable),
    .driveHighSide(driveHighSide),
    .sleep(sleep)
  );
  spi_host_model spi_host_model_i (.core_clk(core_clk), .chip_select_n(chip_select_n), .sclk(sclk), .si(si),
    .so(so), .soOe(soOe));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic frame(input logic [31:0] tx, input int n);
    spi_host_model_i.xfer(tx, n, rx, pre);
  endtask
  task automatic t_sleep();
    frame(32'h1FFE, 16);
    check("disabled answer", 32'hFFFF, rx);
    check("disabled drive", 32'h0, driveEnable);
    check("sleep", 32'h1, sleep);
    enable = 1'b1;
    repeat (4) @(negedge core_clk);
    frame(32'h1FFE, 16);
    check("early drive", 32'h0, driveEnable);
    check("early answer", 32'hFFFF, rx);
    repeat (2000) @(negedge core_clk);
    $display("sleep test done");
  endtask
  task automatic t_groups();
    frame(32'h15E2, 16);
    check("status at wake", 32'h0, rx);
    check("group0 enable", 32'h02B, driveEnable);
    check("group0 side", 32'h021, driveHighSide);
    thermalWarningDetect = 1'b1;
    frame(32'h5A38, 16);
    thermalWarningDetect = 1'b0;
    check("group0 status", 32'h199F, rx);
    check("both enables", 32'hD2B, driveEnable);
    check("both sides", 32'h521, driveHighSide);
    $display("group test done");
  endtask
  task automatic t_errors();
    frame(32'hFFF, 12);
    check("short status", 32'h1E6, rx);
    check("short dropped", 32'hD2B, driveEnable);
    frame(32'hFFFFF, 20);
    check("odd dropped", 32'hD2B, driveEnable);
    frame(32'hA50000, 24);
    check("chained bits", 32'h1E60A5, rx);
    check("last 16 kept", 32'hD00, driveEnable);
    $display("error test done");
  endtask
  task automatic t_faults();
    frame(32'h0080, 16);
    check("channel one on", 32'hD01, driveEnable);
    @(negedge core_clk) overcurrentDetect = 12'h001;
    @(negedge core_clk) overcurrentDetect = 12'h000;
    check("overcurrent off", 32'hD00, driveEnable);
    @(negedge core_clk) thermalShutdownDetect = 1'b1;
    @(negedge core_clk) thermalShutdownDetect = 1'b0;
    check("thermal off", 32'h0, driveEnable);
    frame(32'h0080, 16);
    check("thermal pre-bit", 32'h1, pre);
    check("fault status", 32'h8002, rx);
    frame(32'h8080, 16);
    check("cleared drive", 32'hD01, driveEnable);
    $display("fault test done");
  endtask
  task automatic t_supply();
    frame(32'h2081, 16);
    check("lockout on", 32'hD01, driveEnable);
    @(negedge core_clk) underloadDetect = 12'h001;
    @(negedge core_clk) underloadDetect = 12'h000;
    check("underload off", 32'hD00, driveEnable);
    supplyFault = 1'b1;
    @(negedge core_clk);
    check("supply off", 32'h0, driveEnable);
    frame(32'h0, 16);
    check("supply status", 32'h6004, rx);
    supplyFault = 1'b0;
    @(negedge core_clk);
    check("group0 cleared", 32'hD00, driveEnable);
    $display("supply test done");
  endtask
  task automatic t_wake();
    enable = 1'b0;
    repeat (4) @(negedge core_clk);
    check("sleep again", 32'h1, sleep);
    check("sleep drive", 32'h0, driveEnable);
    enable = 1'b1;
    repeat (2010) @(negedge core_clk);
    check("command cleared", 32'h0, driveEnable);
    frame(32'h0, 16);
    check("status cleared", 32'h0, rx);
    check("pre-bit cleared", 32'h0, pre);
    $display("wake test done");
  endtask
  initial begin
    rst_n = 1'b0;
    enable = 1'b0;
    overcurrentDetect = '0;
    underloadDetect = '0;
    thermalShutdownDetect = 1'b0;
    thermalWarningDetect = 1'b0;
    supplyFault = 1'b0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    t_sleep();
    t_groups();
    t_errors();
    t_faults();
    t_supply();
    t_wake();
    summarize();
  end
endmodule

/* pin_sync.sv */
// Two-flop synchroniser for pins that arrive from outside the core clock domain.
// Assumes asynchronous active-low reset; the first stage feeds only the second.
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Raw pins
  input wire logic [WIDTH-1:0] pinRaw,
  // Synchronised levels
  pin_sync_if.src syncOut
);
  logic [WIDTH-1:0] stageOne;
  logic [WIDTH-1:0] stageTwo;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stageOne <= RESET_LEVEL;
      stageTwo <= RESET_LEVEL;
    end else begin
      stageOne <= pinRaw;
      stageTwo <= stageOne;
    end
  end

  assign syncOut.level = stageTwo;
endmodule

/* pin_sync_if.sv */
// Carries synchronised pin levels from the synchroniser to the port logic.
// Assumes both ends run on the same core clock.
interface pin_sync_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface

/* spi_host_model.sv */
// Serial host model driving select, clock and data of the port.
// Assumes the caller runs on core_clk; released lines rest at their pull levels.
module spi_host_model (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic chip_select_n,
  output logic sclk,
  output logic si,
  input wire logic so,
  input wire logic soOe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // Each clock phase is four core cycles, so the link clock period is 400 ns.
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx, output logic pre);
    rx = '0;
    @(negedge core_clk);
    chip_select_n = 1'b0;
    repeat (8) @(negedge core_clk);
    // An undriven output reads as the inverse of its last level, so a read of a released line stands out.
    pre = soOe ? so : !so;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      sclk = 1'b1;
      repeat (4) @(negedge core_clk);
      rx = {rx[30:0], soOe ? so : !so};
      sclk = 1'b0;
      repeat (4) @(negedge core_clk);
    end
    si = 1'b0;
    chip_select_n = 1'b1;
    repeat (100) @(negedge core_clk);
  endtask
endmodule
